// file: distortion_defines.svh
// Constants of the current distortion alarm monitor
`ifndef DISTORTION_DEFINES_SVH
`define DISTORTION_DEFINES_SVH

// Register offsets
`define REG_CTRL          8'h00
`define REG_PH_THR        8'h04
`define REG_RA_THR        8'h08
`define REG_RB_THR        8'h0c
`define REG_PH_DLY        8'h10
`define REG_RA_DLY        8'h14
`define REG_RB_DLY        8'h18
`define REG_STATUS        8'h1c
`define REG_CNT_START     8'h20
`define REG_CNT_ALARM     8'h24
`define REG_CNT_BLOCKED   8'h28
`define REG_REC_SEL       8'h2c
`define REG_REC_TIME      8'h30
`define REG_REC_INFO      8'h34
`define REG_REC_PH01      8'h38
`define REG_REC_PH2       8'h3c
`define REG_CNT_CLEAR     8'h40
`define REG_EVENT         8'h44

// Control fields
`define CTRL_EN_PH_BIT    0
`define CTRL_EN_RA_BIT    1
`define CTRL_EN_RB_BIT    2
`define CTRL_POWER_BIT    3
`define CTRL_STORE_ON_BIT 4
`define CTRL_STORE_OFF_BIT 5
`define CTRL_RESET        6'h37

// Thresholds in 0.01 % units, delays in 5 ms steps
`define THR_RESET         16'h03e8
`define DLY_RESET         20'h007d0
`define RESET_RATIO_PCT   97
`define RECORD_DEPTH      12

// Timing
`define CLK_PERIOD_NS     50
`define TICK_MS           1
`define TICK_CYCLES       (`TICK_MS * 1000000 / `CLK_PERIOD_NS)
`define STEP_MS           5

`endif

// file: distortion_pkg.sv
// Types of the current distortion alarm monitor
package distortion_pkg;

    typedef enum logic [3:0] {
        COND_NORMAL  = 4'h1,
        COND_START   = 4'h2,
        COND_ALARM   = 4'h4,
        COND_BLOCKED = 4'h8
    } condition_t;

    typedef struct packed {
        logic [15:0] ph1;
        logic [15:0] ph2;
        logic [15:0] ph3;
        logic [15:0] ra;
        logic [15:0] rb;
    } measure_t;

    typedef struct packed {
        logic        on;
        logic [3:0]  code;
        logic [31:0] stamp_ms;
    } event_t;

    typedef struct packed {
        logic [31:0] stamp_ms;
        logic [3:0]  code;
        logic [2:0]  group;
        logic [15:0] ph1;
        logic [15:0] ph2;
        logic [15:0] ph3;
    } record_t;

endpackage

// file: group_pickup.sv
// One channel group: pick-up with hysteresis, blocking and alarm timer
`timescale 1ns/10ps
`default_nettype none
`include "distortion_defines.svh"
module group_pickup #(
    parameter int CHANNELS = 3
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // Timing
    input  wire logic                 step,
    // Settings
    input  wire logic                 enable,
    input  wire logic [15:0]          threshold,
    input  wire logic [19:0]          delay_steps,
    input  wire logic                 block,
    // Measurements
    input  wire logic [CHANNELS*16-1:0] level,
    // Status
    output logic                      start_q,
    output logic                      alarm_q,
    output logic                      blocked_q
);
    logic [CHANNELS-1:0] over;
    logic [CHANNELS-1:0] under;
    logic [CHANNELS-1:0] held_q;
    logic [19:0]         count_q;
    logic                pick;
    logic                start_d;
    logic [31:0]         drop_lvl;

    assign drop_lvl = 32'(threshold) * 32'(`RESET_RATIO_PCT);

    genvar i;
    generate
        for (i = 0; i < CHANNELS; i++) begin : g_ch
            // Each phase judged on its own every cycle
            assign over[i]  = level[i*16 +: 16] > threshold;
            assign under[i] = (32'(level[i*16 +: 16]) * 32'd100) < drop_lvl;
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    held_q[i] <= 1'b0;
                end else if (!enable) begin
                    held_q[i] <= 1'b0;
                end else if (over[i]) begin
                    held_q[i] <= 1'b1;
                end else if (under[i]) begin
                    held_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Any one phase over the shared threshold picks up
    assign pick = |held_q;

    // Disable or block ends start at once, so alarm never outlives it
    assign start_d = pick && !block && enable;

    // Block is sampled before the outcome is judged
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            start_q   <= 1'b0;
            blocked_q <= 1'b0;
        end else begin
            start_q   <= start_d;
            blocked_q <= pick && block;
        end
    end

    // Timer restarts whenever start drops; settings apply live
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= 20'h00000;
            alarm_q <= 1'b0;
        end else if (!start_d) begin
            count_q <= 20'h00000;
            alarm_q <= 1'b0;
        end else if (start_q && count_q >= delay_steps) begin
            alarm_q <= 1'b1;
        end else if (start_q && step) begin
            count_q <= count_q + 20'h00001;
        end
    end

    a_alarm_needs_start: assert property (
        @(posedge clk) disable iff (!resetn)
        alarm_q |-> start_q && $past(enable))
        else $error("alarm without start");
    a_block_no_start: assert property (
        @(posedge clk) disable iff (!resetn)
        block |=> !start_q) else $error("start under block");
    a_disable_clears: assert property (
        @(posedge clk) disable iff (!resetn)
        !enable |=> !start_q && !alarm_q)
        else $error("start or alarm while disabled");
    a_timer_restart: assert property (
        @(posedge clk) disable iff (!resetn)
        !start_q |-> count_q == 20'h00000 && !alarm_q)
        else $error("timer kept without start");
endmodule
`default_nettype wire

// file: distortion_regs.sv
// Distortion ratio from a squared-harmonic sum, amplitude or power form
`timescale 1ns/10ps
`default_nettype none
module distortion_regs (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Method and ratio input
    input  wire logic        power_mode,
    input  wire logic [15:0] power_ratio,
    // Result in 0.01 % units
    output logic [15:0]      ratio_q
);
    logic [15:0] root;
    logic [31:0] scaled;

    // Ratio input holds sum/fund^2 in 0.01 % units; amplitude is the root
    always_comb begin
        logic [15:0] trial;
        root   = 16'h0000;
        trial  = 16'h0000;
        scaled = 32'(power_ratio) * 32'd10000;
        for (int b = 15; b >= 0; b--) begin
            trial = root | (16'h0001 << b);
            if (32'(trial) * 32'(trial) <= scaled) begin
                root = trial;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ratio_q <= 16'h0000;
        end else begin
            ratio_q <= power_mode ? power_ratio : root;
        end
    end
endmodule
`default_nettype wire

// file: current_thd_alarm_monitor.sv
// Current distortion alarm monitor: three groups, events, counters, records
//
// Notes on behaviour
// - Alarm only when group enable is on
// - Drop pick-up below 97 % of threshold
// - Compare each phase separately every cycle
// - One shared phase threshold, any phase
// - Phase threshold 0.01 % steps, default 10 %
// - Residual thresholds own, default 10 %
// - Three enables, all default enabled
// - Sample block before judging pick-up
// - Unblocked pick-up raises start, runs timer
// - Blocked pick-up raises blocked only
// - Block during start clears start
// - Per-group delay, 5 ms steps, 10 s
// - On and off events per status; code emits one per cycle, so alarm off is lost to start off
// - Choose on, off or both stored
// - Resettable start, alarm, blocked counters
// - Keep twelve latest records on rising edges
// - Record holds stamp, event, phases, group
// - Condition: normal, start, alarm, blocked
// - Settings change live without restart
// - Amplitude or power ratio, default amplitude
`timescale 1ns/10ps
`default_nettype none
`include "distortion_defines.svh"
module current_thd_alarm_monitor (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     resetn,
    // Register port
    input  wire logic [7:0]               addr,
    input  wire logic [31:0]              wdata,
    input  wire logic                     wr,
    input  wire logic                     rd,
    output logic [31:0]                   rdata_q,
    // Harmonic front end: squared sum over fundamental, 0.01 %
    input  wire distortion_pkg::measure_t meas,
    // Blocking matrix and setting group
    input  wire logic                     block,
    input  wire logic [2:0]               setting_group,
    // Indications
    output logic [2:0]                    start_out_q,
    output logic [2:0]                    alarm_out_q,
    output logic                          blocked_out_q,
    output distortion_pkg::condition_t    condition_q,
    // Event stream
    output logic                          event_valid_q,
    output distortion_pkg::event_t        event_q
);
    localparam int TICKS = `TICK_CYCLES;
    localparam int DEPTH = `RECORD_DEPTH;

    logic [5:0]  ctrl_q;
    logic [15:0] thr_q [3];
    logic [19:0] dly_q [3];
    logic [15:0] ratio [5];
    logic [2:0]  start_g, alarm_g, blocked_g;
    logic [15:0] tick_q;
    logic [2:0]  ms_q;
    logic        step_q;
    logic [31:0] stamp_q;
    logic [31:0] cnt_start_q, cnt_alarm_q, cnt_blocked_q;
    logic [6:0]  now, prev_q, rise, fall;
    logic [3:0]  rise_code;
    logic [3:0]  wptr_q;
    logic [3:0]  sel_q;
    distortion_pkg::record_t rec_q [DEPTH];
    distortion_pkg::record_t rsel;
    logic [15:0] raw [5];
    logic        any_block;

    assign raw[0] = meas.ph1;
    assign raw[1] = meas.ph2;
    assign raw[2] = meas.ph3;
    assign raw[3] = meas.ra;
    assign raw[4] = meas.rb;

    genvar c;
    generate
        for (c = 0; c < 5; c++) begin : g_ratio
            distortion_regs u_ratio (
                .clk        (clk),
                .resetn     (resetn),
                .power_mode (ctrl_q[`CTRL_POWER_BIT]),
                .power_ratio(raw[c]),
                .ratio_q    (ratio[c])
            );
        end
    endgenerate

    group_pickup #(.CHANNELS(3)) u_phase (
        .clk        (clk),
        .resetn     (resetn),
        .step       (step_q),
        .enable     (ctrl_q[`CTRL_EN_PH_BIT]),
        .threshold  (thr_q[0]),
        .delay_steps(dly_q[0]),
        .block      (block),
        .level      ({ratio[2], ratio[1], ratio[0]}),
        .start_q    (start_g[0]),
        .alarm_q    (alarm_g[0]),
        .blocked_q  (blocked_g[0])
    );
    group_pickup #(.CHANNELS(1)) u_res_a (
        .clk        (clk),
        .resetn     (resetn),
        .step       (step_q),
        .enable     (ctrl_q[`CTRL_EN_RA_BIT]),
        .threshold  (thr_q[1]),
        .delay_steps(dly_q[1]),
        .block      (block),
        .level      (ratio[3]),
        .start_q    (start_g[1]),
        .alarm_q    (alarm_g[1]),
        .blocked_q  (blocked_g[1])
    );
    group_pickup #(.CHANNELS(1)) u_res_b (
        .clk        (clk),
        .resetn     (resetn),
        .step       (step_q),
        .enable     (ctrl_q[`CTRL_EN_RB_BIT]),
        .threshold  (thr_q[2]),
        .delay_steps(dly_q[2]),
        .block      (block),
        .level      (ratio[4]),
        .start_q    (start_g[2]),
        .alarm_q    (alarm_g[2]),
        .blocked_q  (blocked_g[2])
    );

    // Millisecond stamp and 5 ms delay step
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick_q  <= 16'h0000;
            ms_q    <= 3'h0;
            step_q  <= 1'b0;
            stamp_q <= 32'h00000000;
        end else begin
            step_q <= 1'b0;
            if (tick_q == 16'(TICKS - 1)) begin
                tick_q  <= 16'h0000;
                stamp_q <= stamp_q + 32'h00000001;
                if (ms_q == 3'(`STEP_MS - 1)) begin
                    ms_q   <= 3'h0;
                    step_q <= 1'b1;
                end else begin
                    ms_q <= ms_q + 3'h1;
                end
            end else begin
                tick_q <= tick_q + 16'h0001;
            end
        end
    end

    // Settings written live, never restarting the groups
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= `CTRL_RESET;
            for (int g = 0; g < 3; g++) begin
                thr_q[g] <= `THR_RESET;
                dly_q[g] <= `DLY_RESET;
            end
        end else if (wr) begin
            unique case (addr)
                `REG_CTRL:   ctrl_q   <= wdata[5:0];
                `REG_PH_THR: thr_q[0] <= wdata[15:0];
                `REG_RA_THR: thr_q[1] <= wdata[15:0];
                `REG_RB_THR: thr_q[2] <= wdata[15:0];
                `REG_PH_DLY: dly_q[0] <= wdata[19:0];
                `REG_RA_DLY: dly_q[1] <= wdata[19:0];
                `REG_RB_DLY: dly_q[2] <= wdata[19:0];
                default: ;
            endcase
        end
    end

    // Status vector: starts, alarms, blocked
    assign any_block = |blocked_g;
    assign now  = {any_block, alarm_g, start_g};
    assign rise = now & ~prev_q;
    assign fall = ~now & prev_q;

    // Record names its event by the lowest rising status code
    always_comb begin
        rise_code = 4'h0;
        for (int k = 6; k >= 0; k--) begin
            if (rise[k]) begin
                rise_code = 4'(k);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev_q        <= 7'h00;
            start_out_q   <= 3'h0;
            alarm_out_q   <= 3'h0;
            blocked_out_q <= 1'b0;
            condition_q   <= distortion_pkg::COND_NORMAL;
        end else begin
            prev_q        <= now;
            start_out_q   <= start_g;
            alarm_out_q   <= alarm_g;
            blocked_out_q <= any_block;
            if (any_block) begin
                condition_q <= distortion_pkg::COND_BLOCKED;
            end else if (|alarm_g) begin
                condition_q <= distortion_pkg::COND_ALARM;
            end else if (|start_g) begin
                condition_q <= distortion_pkg::COND_START;
            end else begin
                condition_q <= distortion_pkg::COND_NORMAL;
            end
        end
    end

    // One event per cycle, lowest code first; simultaneous others are lost
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            event_valid_q <= 1'b0;
            event_q       <= '0;
        end else begin
            event_valid_q <= 1'b0;
            for (int e = 6; e >= 0; e--) begin
                if (rise[e] && ctrl_q[`CTRL_STORE_ON_BIT]) begin
                    event_valid_q <= 1'b1;
                    event_q <= {1'b1, 4'(e), stamp_q};
                end else if (fall[e] && ctrl_q[`CTRL_STORE_OFF_BIT]) begin
                    event_valid_q <= 1'b1;
                    event_q <= {1'b0, 4'(e), stamp_q};
                end
            end
        end
    end

    // Counters; a new edge wins over a clear in the same cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_start_q   <= 32'h00000000;
            cnt_alarm_q   <= 32'h00000000;
            cnt_blocked_q <= 32'h00000000;
        end else begin
            if (wr && addr == `REG_CNT_CLEAR) begin
                cnt_start_q   <= 32'(|rise[2:0]);
                cnt_alarm_q   <= 32'(|rise[5:3]);
                cnt_blocked_q <= 32'(rise[6]);
            end else begin
                cnt_start_q   <= cnt_start_q + 32'(|rise[2:0]);
                cnt_alarm_q   <= cnt_alarm_q + 32'(|rise[5:3]);
                cnt_blocked_q <= cnt_blocked_q + 32'(rise[6]);
            end
        end
    end

    // Twelve-entry ring of ON-edge records
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wptr_q <= 4'h0;
            for (int r = 0; r < DEPTH; r++) begin
                rec_q[r] <= '0;
            end
        end else if (|rise) begin
            rec_q[wptr_q] <= {stamp_q, rise_code, setting_group,
                              ratio[0], ratio[1], ratio[2]};
            wptr_q <= (wptr_q == 4'(DEPTH - 1)) ? 4'h0
                                                : wptr_q + 4'h1;
        end
    end

    // Record select register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sel_q <= 4'h0;
        end else if (wr && addr == `REG_REC_SEL) begin
            sel_q <= (wdata[3:0] < 4'(DEPTH)) ? wdata[3:0] : 4'h0;
        end
    end

    assign rsel = rec_q[sel_q];

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 32'h00000000;
        end else if (rd) begin
            unique case (addr)
                `REG_CTRL:        rdata_q <= {26'h0, ctrl_q};
                `REG_PH_THR:      rdata_q <= {16'h0, thr_q[0]};
                `REG_RA_THR:      rdata_q <= {16'h0, thr_q[1]};
                `REG_RB_THR:      rdata_q <= {16'h0, thr_q[2]};
                `REG_PH_DLY:      rdata_q <= {12'h0, dly_q[0]};
                `REG_RA_DLY:      rdata_q <= {12'h0, dly_q[1]};
                `REG_RB_DLY:      rdata_q <= {12'h0, dly_q[2]};
                `REG_STATUS:      rdata_q <= {21'h0, condition_q, now};
                `REG_CNT_START:   rdata_q <= cnt_start_q;
                `REG_CNT_ALARM:   rdata_q <= cnt_alarm_q;
                `REG_CNT_BLOCKED: rdata_q <= cnt_blocked_q;
                `REG_REC_SEL:     rdata_q <= {24'h0, wptr_q, sel_q};
                `REG_REC_TIME:    rdata_q <= rsel.stamp_ms;
                `REG_REC_INFO:    rdata_q <= {25'h0, rsel.code, rsel.group};
                `REG_REC_PH01:    rdata_q <= {rsel.ph2, rsel.ph1};
                `REG_REC_PH2:     rdata_q <= {16'h0, rsel.ph3};
                default:          rdata_q <= 32'h00000000;
            endcase
        end else begin
            rdata_q <= 32'h00000000;
        end
    end

    sequence s_block_rise;
        !blocked_out_q ##1 blocked_out_q;
    endsequence
    a_block_counted: assert property (
        @(posedge clk) disable iff (!resetn)
        rise[6] && !(wr && addr == `REG_CNT_CLEAR) |=>
        cnt_blocked_q == $past(cnt_blocked_q) + 32'h1)
        else $error("blocked edge not counted");
    a_block_cond: assert property (
        @(posedge clk) disable iff (!resetn)
        s_block_rise |-> condition_q == distortion_pkg::COND_BLOCKED)
        else $error("condition not blocked");
    a_record_ptr: assert property (
        @(posedge clk) disable iff (!resetn)
        wptr_q < 4'(DEPTH)) else $error("record pointer out of range");
    a_alarm_enabled: assert property (
        @(posedge clk) disable iff (!resetn)
        alarm_g[0] |-> $past(ctrl_q[`CTRL_EN_PH_BIT]))
        else $error("phase alarm while disabled");
    a_on_event_gate: assert property (
        @(posedge clk) disable iff (!resetn)
        event_valid_q && event_q.on |-> $past(ctrl_q[`CTRL_STORE_ON_BIT]))
        else $error("on event while not selected");
    a_start_unblocked: assert property (
        @(posedge clk) disable iff (!resetn)
        block ##1 block |-> start_g == 3'h0)
        else $error("start held under block");
    a_alarm_delay: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(alarm_g[0]) |-> start_g[0] && $past(start_g[0]))
        else $error("alarm without running start");
    a_thr_default: assert property (
        @(posedge clk)
        $rose(resetn) |-> thr_q[0] == `THR_RESET)
        else $error("threshold default wrong");
endmodule
`default_nettype wire

// file: meas_source.sv
// Model of the harmonic front end and the blocking matrix
`timescale 1ns/10ps
`default_nettype none
module meas_source #(
    parameter int REFRESH = 4
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     resetn,
    // Values the bench wants shown
    input  wire distortion_pkg::measure_t target,
    input  wire logic                     block_req,
    // Towards the monitor
    output distortion_pkg::measure_t      meas,
    output logic                          block
);
    int cnt_q;
    // Ratios move only on the refresh time base, shortened for the run
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 0;
            meas  <= '0;
        end else if (cnt_q == REFRESH - 1) begin
            cnt_q <= 0;
            meas  <= target;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
    // Bench raises it well ahead of any running delay
    assign block = block_req;
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench of the current distortion alarm monitor
`timescale 1ns/10ps
`default_nettype none
`include "distortion_defines.svh"
module tb_top;
    logic                     clk = 1'b0;
    logic                     resetn = 1'b0;
    logic [7:0]               addr = 8'h00;
    logic [31:0]              wdata = 32'h0;
    logic                     wr = 1'b0;
    logic                     rd = 1'b0;
    logic [31:0]              rdata_q;
    distortion_pkg::measure_t tgt = '0;
    distortion_pkg::measure_t meas;
    logic                     blk = 1'b0;
    logic                     block;
    logic [2:0]               start_out_q;
    logic [2:0]               alarm_out_q;
    logic                     blocked_out_q;
    distortion_pkg::condition_t condition_q;
    logic                     event_valid_q;
    distortion_pkg::event_t   event_q;
    distortion_pkg::event_t   evq[$];
    logic [6:0]               mon;
    int                       bad_count = 0;
    int                       checks_done = 0;

    always #25 clk = ~clk;
    assign mon = {blocked_out_q, alarm_out_q, start_out_q};
    always @(posedge clk) if (event_valid_q === 1'b1) evq.push_back(event_q);

    meas_source #(.REFRESH(4)) src (.clk(clk), .resetn(resetn),
        .target(tgt), .block_req(blk), .meas(meas), .block(block));
    current_thd_alarm_monitor dut (.clk(clk), .resetn(resetn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .meas(meas),
        .block(block), .setting_group(3'h2), .start_out_q(start_out_q),
        .alarm_out_q(alarm_out_q), .blocked_out_q(blocked_out_q),
        .condition_q(condition_q), .event_valid_q(event_valid_q),
        .event_q(event_q));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata_q, exp);
    endtask

    // Bounded wait on one indication bit, then judge it
    // Ends on a rising edge so that the next drive lands there
    task automatic wait_mon(input int b, input logic v);
        @(negedge clk);
        for (int i = 0; i < 40 && mon[b] !== v; i++) @(negedge clk);
        chk({31'h0, mon[b]}, {31'h0, v});
        @(posedge clk);
    endtask

    task automatic t_reset;
        rd_chk(`REG_CTRL, 32'h0000_0037);
        rd_chk(`REG_PH_THR, 32'h0000_03e8);
        rd_chk(`REG_RA_THR, 32'h0000_03e8);
        rd_chk(`REG_RB_THR, 32'h0000_03e8);
        rd_chk(`REG_PH_DLY, 32'h0000_07d0);
        rd_chk(8'h7c, 32'h0);
        chk({28'h0, condition_q}, 32'h1);
    endtask

    task automatic t_phase;
        wr_reg(`REG_CTRL, 32'h3f);
        wr_reg(`REG_PH_DLY, 32'h0);
        wr_reg(`REG_CNT_CLEAR, 32'h0);
        evq.delete();
        tgt.ph3 <= 16'd1001;
        wait_mon(0, 1'b1);
        wait_mon(3, 1'b1);
        chk({28'h0, condition_q}, 32'h4);
        chk({31'h0, evq[0].on}, 32'h1);
        chk({28'h0, evq[0].code}, 32'h0);
        tgt.ph3 <= 16'd971;
        repeat (20) @(negedge clk);
        chk({31'h0, mon[0]}, 32'h1);
        @(posedge clk);
        tgt.ph3 <= 16'd969;
        wait_mon(0, 1'b0);
        chk({31'h0, mon[3]}, 32'h0);
        rd_chk(`REG_CNT_START, 32'h1);
        rd_chk(`REG_CNT_ALARM, 32'h1);
        rd_chk(`REG_REC_INFO, 32'h0000_0002);
        rd_chk(`REG_REC_PH2, 32'h0000_03e9);
        wr_reg(`REG_REC_SEL, 32'h1);
        rd_chk(`REG_REC_SEL, 32'h0000_0021);
        rd_chk(`REG_REC_INFO, 32'h0000_001a);
    endtask

    // 1.01 % power is about 10.05 % amplitude: picks up only as a root
    task automatic t_enable;
        wr_reg(`REG_CTRL, 32'h35);
        tgt.ra <= 16'd2000;
        tgt.rb <= 16'd101;
        wait_mon(2, 1'b1);
        chk({31'h0, mon[1]}, 32'h0);
        tgt <= '0;
        wait_mon(2, 1'b0);
    endtask

    task automatic t_block;
        wr_reg(`REG_PH_DLY, 32'h64);
        blk <= 1'b1;
        tgt.ph1 <= 16'd1001;
        wait_mon(6, 1'b1);
        chk({31'h0, mon[0]}, 32'h0);
        tgt <= '0;
        wait_mon(6, 1'b0);
        blk <= 1'b0;
        tgt.ph1 <= 16'd1001;
        wait_mon(0, 1'b1);
        blk <= 1'b1;
        wait_mon(0, 1'b0);
        chk({31'h0, mon[6]}, 32'h1);
        rd_chk(`REG_CNT_BLOCKED, 32'h2);
    endtask

    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_phase();
        t_enable();
        t_block();
        stop_test();
    end

    initial begin
        #1000000;
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire
